// File: inc/iopcn_defines.svh
`ifndef IOPCN_DEFINES_SVH
`define IOPCN_DEFINES_SVH

`define IOPCN_ADDR_W 5
`define IOPCN_OFF_DIR 5'h00
`define IOPCN_OFF_HOLD 5'h01
`define IOPCN_OFF_PORT 5'h02
`define IOPCN_OFF_ODC 5'h03
`define IOPCN_OFF_ANCFG 5'h04
`define IOPCN_OFF_CNEN_LO 5'h05
`define IOPCN_OFF_CNEN_HI 5'h06
`define IOPCN_OFF_CNPU_LO 5'h07
`define IOPCN_OFF_CNPU_HI 5'h08
`define IOPCN_OFF_INT1SEL 5'h09
`define IOPCN_OFF_OMAP_10_11 5'h0A
`define IOPCN_OFF_OMAP_12_13 5'h0B
`define IOPCN_OFF_OMAP_18_19 5'h0C
`define IOPCN_OFF_OMAP_20_21 5'h0D
`define IOPCN_OFF_IRQ_STAT 5'h0E
`define IOPCN_OFF_IRQ_MASK 5'h0F
`define IOPCN_OFF_CN_PINS 5'h10

`define IOPCN_RST_DIR 16'hFFFF
`define IOPCN_RST_ANCFG 16'h0000
`define IOPCN_RST_INT1SEL 16'h1F00
`define IOPCN_RST_OMAP 16'h0000
`define IOPCN_MASK_MAP_HI 16'h1F00
`define IOPCN_MASK_MAP_LO 16'h001F
`define IOPCN_MASK_CN_HI 16'h7FFF
`define IOPCN_FLD_HI_LSB 8
`define IOPCN_FLD_LO_LSB 0
`define IOPCN_CN_PINS 31
`define IOPCN_IRQ_BITS 2
`define IOPCN_IRQ_CN 0
`define IOPCN_IRQ_INT1 1

`endif

// File: inc/iopcn_pkg.sv
package iopcn_pkg;
    typedef logic [15:0] iopcn_word_t;
    typedef logic [4:0] iopcn_code_t;
    typedef logic [30:0] iopcn_cn_t;
endpackage

// File: inc/iopcn_sync_if.sv
interface iopcn_sync_if #(parameter int W = 16);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface

// File: hw/iopcn_sync.sv
module iopcn_sync
    import iopcn_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Asynchronous levels in, synchronised levels out.
    iopcn_sync_if.snk s
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= s.raw;
            sync_q <= meta_q;
        end
    end

    assign s.synced = sync_q;
endmodule

// File: hw/iopcn_cn_detect.sv
`include "iopcn_defines.svh"
module iopcn_cn_detect
    import iopcn_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Synchronised change-notice pin levels and enables.
    input wire iopcn_cn_t level_i,
    input wire iopcn_cn_t enable_i,
    // Asynchronous wake request for sleep, and clocked change pulse.
    input wire iopcn_cn_t raw_i,
    output logic wake_o,
    output logic change_o
);
    iopcn_cn_t prev_q;
    iopcn_cn_t snap_q;
    logic change_q;
    wire iopcn_cn_t diff = (level_i ^ prev_q) & enable_i;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prev_q <= '0;
            snap_q <= '0;
            change_q <= 1'b0;
        end else begin
            prev_q <= level_i;
            snap_q <= level_i;
            change_q <= |diff;
        end
    end

    // Compares the raw pins to the last snapshot without a clock, so a change wakes a stopped core.
    assign wake_o = |((raw_i ^ snap_q) & enable_i);
    assign change_o = change_q;
endmodule

// File: hw/iopcn_top.sv
// Overview of operation
// - Open-drain bit set makes its pin drive low only, never high.
// - Analog configuration register resets to zero, so shared pins start analog.
// - Port reads return zero for every pin configured as analog.
// - Only analog-configured pins are connected to the converter.
// - Port reads sample the pin levels, not the output hold register.
// - Change detection works without a clock, for sleep wake-up.
// - Up to 31 change-notice inputs can be enabled.
// - Each enable bit lets its pin raise the change interrupt.
// - Each change-notice pin has a weak pull-up enabled by its bit.
// - Output map registers hold the higher pin's function code in bits 12-8.
// - Output map registers hold the lower pin's code in bits 4-0, reset zero.
// - Pin-select bits 15-13 and 7-5 ignore writes and read zero.
`include "iopcn_defines.svh"
module iopcn_top
    import iopcn_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Register port.
    input wire logic [`IOPCN_ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Port pins.
    input wire logic [15:0] pin_i,
    output logic [15:0] pin_o,
    output logic [15:0] pin_oe_o,
    output logic [15:0] analog_conn_o,
    // Change-notice pins and pull-ups.
    input wire logic [30:0] cn_pin_i,
    output logic [30:0] pullup_en_o,
    // Remappable pins and peripheral routing.
    input wire logic [25:0] remap_pin_i,
    input wire logic [31:0] periph_out_i,
    output logic [7:0] remap_out_o,
    output logic ext_int1_o,
    // Interrupts.
    output logic irq_o,
    output logic cn_wake_o
);
    iopcn_word_t dir_q, hold_q, odc_q, ancfg_q;
    iopcn_word_t cnen_lo_q, cnen_hi_q, cnpu_lo_q, cnpu_hi_q;
    iopcn_code_t int1_sel_q;
    iopcn_code_t omap_q [8];
    logic [`IOPCN_IRQ_BITS-1:0] stat_q, mask_q;
    logic [15:0] rdata_q;
    logic int1_prev_q;

    iopcn_sync_if #(.W(16)) port_s ();
    iopcn_sync_if #(.W(31)) cn_s ();
    iopcn_sync_if #(.W(26)) rp_s ();
    assign port_s.raw = pin_i;
    assign cn_s.raw = cn_pin_i;
    assign rp_s.raw = remap_pin_i;

    iopcn_sync #(.W(16)) u_port_sync (.clk_i(clk_i), .srst_i(srst_i), .s(port_s));
    iopcn_sync #(.W(31)) u_cn_sync (.clk_i(clk_i), .srst_i(srst_i), .s(cn_s));
    iopcn_sync #(.W(26)) u_rp_sync (.clk_i(clk_i), .srst_i(srst_i), .s(rp_s));

    // Write decode.
    wire wr_dir = wr_i && addr_i == `IOPCN_OFF_DIR;
    wire wr_hold = wr_i && addr_i == `IOPCN_OFF_HOLD;
    wire wr_port = wr_i && addr_i == `IOPCN_OFF_PORT;
    wire wr_odc = wr_i && addr_i == `IOPCN_OFF_ODC;
    wire wr_ancfg = wr_i && addr_i == `IOPCN_OFF_ANCFG;
    wire wr_cnen_lo = wr_i && addr_i == `IOPCN_OFF_CNEN_LO;
    wire wr_cnen_hi = wr_i && addr_i == `IOPCN_OFF_CNEN_HI;
    wire wr_cnpu_lo = wr_i && addr_i == `IOPCN_OFF_CNPU_LO;
    wire wr_cnpu_hi = wr_i && addr_i == `IOPCN_OFF_CNPU_HI;
    wire wr_int1 = wr_i && addr_i == `IOPCN_OFF_INT1SEL;
    wire wr_stat = wr_i && addr_i == `IOPCN_OFF_IRQ_STAT;
    wire wr_mask = wr_i && addr_i == `IOPCN_OFF_IRQ_MASK;
    wire [3:0] wr_omap = {wr_i && addr_i == `IOPCN_OFF_OMAP_20_21, wr_i && addr_i == `IOPCN_OFF_OMAP_18_19,
                          wr_i && addr_i == `IOPCN_OFF_OMAP_12_13, wr_i && addr_i == `IOPCN_OFF_OMAP_10_11};

    // Port reads take pin levels, with analog pins forced low.
    wire iopcn_word_t port_view = port_s.synced & ancfg_q;
    wire iopcn_cn_t cn_enable = {cnen_hi_q[14:0], cnen_lo_q};
    wire iopcn_cn_t cn_level = cn_s.synced;

    // Change detection and external interrupt 1.
    logic cn_change;
    iopcn_cn_detect u_cn_detect (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .level_i(cn_level),
        .enable_i(cn_enable),
        .raw_i(cn_pin_i),
        .wake_o(cn_wake_o),
        .change_o(cn_change)
    );

    wire int1_level = (int1_sel_q < 5'd26) ? rp_s.synced[int1_sel_q] : 1'b0;
    wire int1_rise = int1_level && !int1_prev_q;
    wire [`IOPCN_IRQ_BITS-1:0] irq_set = {int1_rise, cn_change};

    // Read mux.
    logic [15:0] rd_mux;
    always_comb begin
        case (addr_i)
            `IOPCN_OFF_DIR: rd_mux = dir_q;
            `IOPCN_OFF_HOLD: rd_mux = hold_q;
            `IOPCN_OFF_PORT: rd_mux = port_view;
            `IOPCN_OFF_ODC: rd_mux = odc_q;
            `IOPCN_OFF_ANCFG: rd_mux = ancfg_q;
            `IOPCN_OFF_CNEN_LO: rd_mux = cnen_lo_q;
            `IOPCN_OFF_CNEN_HI: rd_mux = cnen_hi_q;
            `IOPCN_OFF_CNPU_LO: rd_mux = cnpu_lo_q;
            `IOPCN_OFF_CNPU_HI: rd_mux = cnpu_hi_q;
            `IOPCN_OFF_INT1SEL: rd_mux = {3'h0, int1_sel_q, 8'h00};
            `IOPCN_OFF_OMAP_10_11: rd_mux = {3'h0, omap_q[1], 3'h0, omap_q[0]};
            `IOPCN_OFF_OMAP_12_13: rd_mux = {3'h0, omap_q[3], 3'h0, omap_q[2]};
            `IOPCN_OFF_OMAP_18_19: rd_mux = {3'h0, omap_q[5], 3'h0, omap_q[4]};
            `IOPCN_OFF_OMAP_20_21: rd_mux = {3'h0, omap_q[7], 3'h0, omap_q[6]};
            `IOPCN_OFF_IRQ_STAT: rd_mux = {14'h0000, stat_q};
            `IOPCN_OFF_IRQ_MASK: rd_mux = {14'h0000, mask_q};
            `IOPCN_OFF_CN_PINS: rd_mux = cn_level[15:0];
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dir_q <= `IOPCN_RST_DIR;
            hold_q <= '0;
            odc_q <= '0;
            ancfg_q <= `IOPCN_RST_ANCFG;
            cnen_lo_q <= '0;
            cnen_hi_q <= '0;
            cnpu_lo_q <= '0;
            cnpu_hi_q <= '0;
            int1_sel_q <= 5'(`IOPCN_RST_INT1SEL >> `IOPCN_FLD_HI_LSB);
        end else begin
            if (wr_dir) begin
                dir_q <= wdata_i;
            end
            if (wr_hold || wr_port) begin
                hold_q <= wdata_i;
            end
            if (wr_odc) begin
                odc_q <= wdata_i;
            end
            if (wr_ancfg) begin
                ancfg_q <= wdata_i;
            end
            if (wr_cnen_lo) begin
                cnen_lo_q <= wdata_i;
            end
            if (wr_cnen_hi) begin
                cnen_hi_q <= wdata_i & `IOPCN_MASK_CN_HI;
            end
            if (wr_cnpu_lo) begin
                cnpu_lo_q <= wdata_i;
            end
            if (wr_cnpu_hi) begin
                cnpu_hi_q <= wdata_i & `IOPCN_MASK_CN_HI;
            end
            if (wr_int1) begin
                int1_sel_q <= wdata_i[12:8];
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_omap
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                omap_q[2*g] <= '0;
                omap_q[2*g+1] <= '0;
            end else if (wr_omap[g]) begin
                omap_q[2*g] <= wdata_i[4:0];
                omap_q[2*g+1] <= wdata_i[12:8];
            end
        end
        assign remap_out_o[2*g] = periph_out_i[omap_q[2*g]];
        assign remap_out_o[2*g+1] = periph_out_i[omap_q[2*g+1]];
    end

    // Sticky status: a new event wins over a write-one clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stat_q <= '0;
            mask_q <= '0;
            int1_prev_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            stat_q <= (stat_q & ~(wr_stat ? wdata_i[1:0] : 2'b00)) | irq_set;
            if (wr_mask) begin
                mask_q <= wdata_i[1:0];
            end
            int1_prev_q <= int1_level;
            rdata_q <= rd_i ? rd_mux : 16'h0000;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = |(stat_q & mask_q);
    assign ext_int1_o = int1_level;

    // Pin drive: open-drain pins only pull low.
    assign pin_o = hold_q;
    assign pin_oe_o = ~dir_q & (~odc_q | ~hold_q);
    assign analog_conn_o = ~ancfg_q;
    assign pullup_en_o = {cnpu_hi_q[14:0], cnpu_lo_q};

    property p_od_no_high;
        @(posedge clk_i) disable iff (srst_i)
        (odc_q != 16'h0000) |-> ((pin_oe_o & odc_q & pin_o) == 16'h0000);
    endproperty
    a_od_no_high: assert property (p_od_no_high) else $error("Open-drain pin driven high.");

    property p_analog_reads_low;
        @(posedge clk_i) disable iff (srst_i)
        (rd_i && addr_i == `IOPCN_OFF_PORT) |=> ((rdata_o & ~ancfg_q) == 16'h0000);
    endproperty
    a_analog_reads_low: assert property (p_analog_reads_low) else $error("Analog pin read high.");

    property p_port_reads_pin;
        @(posedge clk_i) disable iff (srst_i)
        (rd_i && addr_i == `IOPCN_OFF_PORT) |=> (rdata_o == ($past(pin_i, 3) & ancfg_q)) || $changed(ancfg_q)
            || !$stable(pin_i);
    endproperty
    a_port_reads_pin: assert property (p_port_reads_pin) else $error("Port read not the pin level.");

    property p_cn_change;
        @(posedge clk_i) disable iff (srst_i)
        (((cn_level ^ $past(cn_level)) & cn_enable) != '0) |-> ##2 stat_q[`IOPCN_IRQ_CN];
    endproperty
    a_cn_change: assert property (p_cn_change) else $error("Change event not flagged.");

    property p_map_unimpl_zero;
        @(posedge clk_i) disable iff (srst_i)
        (rd_i && addr_i >= `IOPCN_OFF_INT1SEL && addr_i <= `IOPCN_OFF_OMAP_20_21) |=> ((rdata_o & 16'hE0E0) == 16'h0000);
    endproperty
    a_map_unimpl_zero: assert property (p_map_unimpl_zero) else $error("Unimplemented bits read nonzero.");

    property p_omap_write;
        @(posedge clk_i) disable iff (srst_i)
        wr_omap[0] |=> (omap_q[1] == $past(wdata_i[12:8]) && omap_q[0] == $past(wdata_i[4:0]));
    endproperty
    a_omap_write: assert property (p_omap_write) else $error("Output map fields wrong.");

    property p_int1_reset;
        @(posedge clk_i) $fell(srst_i) |-> (int1_sel_q == 5'h1F && ancfg_q == 16'h0000);
    endproperty
    a_int1_reset: assert property (p_int1_reset) else $error("Reset values wrong.");

    property p_pullup_map;
        @(posedge clk_i) disable iff (srst_i)
        wr_cnpu_lo |=> (pullup_en_o[15:0] == $past(wdata_i));
    endproperty
    a_pullup_map: assert property (p_pullup_map) else $error("Pull-up enable mismatch.");

    property p_irq_level;
        @(posedge clk_i) disable iff (srst_i)
        (stat_q[`IOPCN_IRQ_CN] && mask_q[`IOPCN_IRQ_CN]) |-> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt not raised.");
endmodule

// File: testbench/iopcn_pins_model.sv
module iopcn_pins_model (
    // Clock.
    input wire logic clk_i,
    // Port pads.
    input wire logic [15:0] drv_i,
    input wire logic [15:0] oe_i,
    input wire logic [15:0] ext_i,
    output logic [15:0] pad_o,
    // Change-notice pads.
    input wire logic [30:0] pullup_i,
    input wire logic [30:0] cn_ext_i,
    input wire logic [30:0] cn_float_i,
    output logic [30:0] cn_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_q = 1'h0;

    always @(posedge clk_i) begin
        flip_q <= ~flip_q;
    end
    // A released pad shows the external level; an open-drain high therefore rests on the outside pull-up.
    assign pad_o = (oe_i & drv_i) | (~oe_i & ext_i);
    // A floating pad without its weak pull-up wanders every cycle instead of keeping a stale value.
    assign cn_o = (cn_float_i & (pullup_i | {31{flip_q}})) | (~cn_float_i & cn_ext_i);
endmodule

// File: testbench/tb.sv
`include "iopcn_defines.svh"
module tb
    import iopcn_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, srst_i, wr_i, rd_i, ext_int1_o, irq_o, cn_wake_o;
    logic [4:0] addr_i;
    iopcn_word_t wdata_i, rdata_o, pin_i, pin_o, pin_oe_o, analog_conn_o, ext_lvl, d, h, a;
    iopcn_cn_t cn_pin_i, pullup_en_o, cn_ext, cn_float;
    logic [25:0] remap_pin_i;
    logic [31:0] periph_out_i;
    logic [7:0] remap_out_o;
    int errors, cmp_count, cyc, k;
    iopcn_word_t mv[9];
    logic [4:0] offs[9] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h09, 5'h05, 5'h06, 5'h07, 5'h08};
    iopcn_word_t msk[9] = '{16'h1F1F, 16'h1F1F, 16'h1F1F, 16'h1F1F, 16'h1F00, 16'hFFFF, 16'h7FFF, 16'hFFFF, 16'h7FFF};

    iopcn_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .analog_conn_o(analog_conn_o), .cn_pin_i(cn_pin_i), .pullup_en_o(pullup_en_o),
        .remap_pin_i(remap_pin_i), .periph_out_i(periph_out_i), .remap_out_o(remap_out_o),
        .ext_int1_o(ext_int1_o), .irq_o(irq_o), .cn_wake_o(cn_wake_o));
    iopcn_pins_model pins_u (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o), .ext_i(ext_lvl), .pad_o(pin_i),
        .pullup_i(pullup_en_o), .cn_ext_i(cn_ext), .cn_float_i(cn_float), .cn_o(cn_pin_i));

    // Function code of remapped output p (bit 0 is pin 10), from the map words last written.
    function automatic logic [4:0] map_code(input int p);
        return p[0] ? mv[p >> 1][12:8] : mv[p >> 1][4:0];
    endfunction

    task automatic summarize();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input iopcn_word_t got, input iopcn_word_t exp, input string s);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] ad, input iopcn_word_t dv);
        @(posedge clk_i);
        addr_i <= ad;
        wdata_i <= dv;
        wr_i <= 1'h1;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask
    task automatic rdchk(input logic [4:0] ad, input iopcn_word_t m, input iopcn_word_t e, input string s);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i <= 1'h1;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1 chk(rdata_o & m, e, s);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    initial begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        {srst_i, wr_i, rd_i, addr_i, wdata_i, cn_ext, cn_float, cyc} = '0;
        srst_i = 1'h1;
        k = $urandom(68);
        ext_lvl = $urandom;
        remap_pin_i = $urandom;
        periph_out_i = $urandom;
        repeat (6) @(posedge clk_i);
        srst_i <= 1'h0;
        rdchk(`IOPCN_OFF_DIR, 16'hFFFF, `IOPCN_RST_DIR, "dir reset");
        rdchk(`IOPCN_OFF_ANCFG, 16'hFFFF, 16'h0000, "analog cfg reset");
        rdchk(`IOPCN_OFF_INT1SEL, 16'hFFFF, 16'h1F00, "int1 select reset");
        for (k = 0; k < 4; k++) rdchk(offs[k], 16'hFFFF, 16'h0000, "map reset");
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 9; i++) begin
                mv[i] = j ? 16'($urandom) : 16'hFFFF;
                wr(offs[i], mv[i]);
                rdchk(offs[i], 16'hFFFF, mv[i] & msk[i], "readback");
            end
        end
        chk(16'(pullup_en_o), 16'(mv[7]), "pullup low");
        chk(16'(pullup_en_o >> 16), mv[8] & 16'h7FFF, "pullup high");
        for (int p = 0; p < 8; p++) chk(16'(remap_out_o[p]), 16'(periph_out_i[map_code(p)]), "remap");
        foreach (offs[i]) if (i > 4) wr(offs[i], 16'h0000);
        for (int i = 0; i < 5; i++) begin
            k = (i == 0) ? 0 : (i == 1) ? 25 : (i == 2) ? 26 : $urandom_range(25);
            wr(`IOPCN_OFF_INT1SEL, 16'(k << 8));
            remap_pin_i <= $urandom;
            idle(4);
            chk(16'(ext_int1_o), (k < 26) ? 16'(remap_pin_i[k]) : 16'h0000, "int1 route");
        end
        for (int i = 0; i < 4; i++) begin
            a = i ? 16'($urandom) : 16'h0000;
            h = $urandom;
            ext_lvl <= $urandom;
            wr(`IOPCN_OFF_HOLD, h);
            wr(`IOPCN_OFF_ANCFG, a);
            idle(3);
            rdchk(`IOPCN_OFF_PORT, 16'hFFFF, ext_lvl & a, "port read");
            chk(analog_conn_o, ~a, "converter link");
        end
        wr(`IOPCN_OFF_DIR, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            a = i ? 16'($urandom) : 16'hFFFF;
            h = $urandom;
            wr(`IOPCN_OFF_ODC, a);
            wr(`IOPCN_OFF_HOLD, h);
            idle(1);
            chk(pin_oe_o, ~(a & h), "open drain enable");
            chk(pin_o, h, "pin drive");
        end
        wr(`IOPCN_OFF_DIR, 16'hFFFF);
        k = $urandom_range(14);
        wr(`IOPCN_OFF_CNEN_LO, 16'(1 << k));
        wr(`IOPCN_OFF_IRQ_MASK, 16'h0001);
        idle(5);
        wr(`IOPCN_OFF_IRQ_STAT, 16'h0003);
        cn_ext[k + 1] <= 1'h1;
        idle(6);
        chk(16'(irq_o), 16'h0000, "disabled pin change");
        cn_ext[k] <= 1'h1;
        #1 chk(16'(cn_wake_o), 16'h0001, "clockless wake");
        idle(5);
        chk(16'(irq_o), 16'h0001, "change irq");
        rdchk(`IOPCN_OFF_IRQ_STAT, 16'h0001, 16'h0001, "change status");
        wr(`IOPCN_OFF_IRQ_STAT, 16'h0001);
        idle(1);
        chk(16'(irq_o), 16'h0000, "status clear");
        wr(`IOPCN_OFF_CNEN_LO, 16'h0000);
        cn_float[3] <= 1'h1;
        wr(`IOPCN_OFF_CNPU_LO, 16'h0008);
        idle(4);
        rdchk(`IOPCN_OFF_CN_PINS, 16'h0008, 16'h0008, "pull-up level");
        summarize();
    end
endmodule
